// *** inc/vcmp_regs.svh ***
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: Printed offsets are indices; byte address is four times the index
`ifndef VCMP_REGS_SVH
`define VCMP_REGS_SVH

// ==========================================================
// Register indices and byte addresses
`define VCMP_IDX_MAIN 4'h0
`define VCMP_IDX_MUX 4'h2
`define VCMP_IDX_IRQEN 4'h6
`define VCMP_IDX_STAT 4'h7
`define VCMP_ADDR_W 6
`define VCMP_ADDR_MAIN 6'h00
`define VCMP_ADDR_MUX 6'h08
`define VCMP_ADDR_IRQEN 6'h18
`define VCMP_ADDR_STAT 6'h1c

// ==========================================================
// Field positions
`define VCMP_MAIN_ENABLE 0
`define VCMP_MAIN_HYS_LO 1
`define VCMP_MAIN_LP 3
`define VCMP_MAIN_EDGE_LO 4
`define VCMP_MAIN_PAD 6
`define VCMP_MAIN_RUNSTBY 7
`define VCMP_MUX_NEG_LO 0
`define VCMP_MUX_INVERT 7
`define VCMP_STAT_FLAG 0
`define VCMP_STAT_STATE 4

// ==========================================================
// Reset values and write masks
`define VCMP_RST_MAIN 8'h00
`define VCMP_RST_MUX 8'h00
`define VCMP_RST_IRQEN 8'h00
`define VCMP_MASK_MUX 8'h83
`define VCMP_MASK_IRQEN 8'h01

// ==========================================================
// Start-up times in ns and derived cycle counts at 10 MHz
`define VCMP_CLK_NS 100
`define VCMP_START_NS 2500
`define VCMP_VREF_START_NS 60000
`define VCMP_START_CYC ((`VCMP_START_NS + `VCMP_CLK_NS - 1) / `VCMP_CLK_NS)
`define VCMP_VREF_START_CYC ((`VCMP_VREF_START_NS + `VCMP_CLK_NS - 1) / `VCMP_CLK_NS)

`endif

// *** inc/vcmp_pkg.sv ***
// Purpose: Types shared by the comparator control files
// Assumes: Nothing beyond the register header
// Notes: Field encodings as enums, core control as a packed struct
package vcmp_pkg;

	// ==========================================================
	// Edge selection for the interrupt flag
	typedef enum logic [1:0] {
		VCMP_EDGE_BOTH = 2'h0,
		VCMP_EDGE_RSVD = 2'h1,
		VCMP_EDGE_FALL = 2'h2,
		VCMP_EDGE_RISE = 2'h3
	} vcmp_edge_t;

	// Negative input source
	typedef enum logic [1:0] {
		VCMP_NEG_PIN = 2'h0,
		VCMP_NEG_RSVD = 2'h1,
		VCMP_NEG_VREF = 2'h2,
		VCMP_NEG_DAC = 2'h3
	} vcmp_neg_t;

	// Sleep states of the system
	typedef enum logic [1:0] {
		VCMP_SLP_ACTIVE = 2'h0,
		VCMP_SLP_IDLE = 2'h1,
		VCMP_SLP_STANDBY = 2'h2,
		VCMP_SLP_PDOWN = 2'h3
	} vcmp_sleep_t;

	// Controls carried to the analog core
	typedef struct packed {
		logic enable;
		logic low_current_select;
		logic [1:0] hysteresis_select;
		vcmp_neg_t negative_source_select;
	} vcmp_core_ctl_t;

endpackage : vcmp_pkg

// *** logic/vcmp_sync.sv ***
// Purpose: Two-stage synchroniser plus edge register for the core output
// Assumes: Input is asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module vcmp_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic async_in,
	output logic sync_out,
	output logic sync_prev
);
	import vcmp_pkg::*;

	logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

	// ==========================================================
	// Next values
	always_comb begin
		s1_d = async_in;
		s2_d = s1_q;
		s3_d = s2_q;
	end

	// Registers; third stage gives the previous value for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end

	assign sync_out = s2_q;
	assign sync_prev = s3_q;
endmodule : vcmp_sync

// *** logic/vcmp_startup.sv ***
// Purpose: Start-up timer that masks the result after enable
// Assumes: Count values given by the parent
// Notes: Restarts on every rising edge of enable
`timescale 1ns/100ps
module vcmp_startup #(
	parameter int CNT_W = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic enable,
	input wire logic [CNT_W-1:0] load_val,
	output logic ready
);
	import vcmp_pkg::*;

	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic en_q, en_d;

	// ==========================================================
	// Load on enable rise, count down while enabled
	always_comb begin
		en_d = enable;
		cnt_d = cnt_q;
		if (!enable) begin
			cnt_d = '0;
		end else if (!en_q) begin
			cnt_d = load_val;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			en_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			en_q <= en_d;
		end
	end

	// Valid once enabled for a cycle and the count is spent
	assign ready = enable && en_q && (cnt_q == '0);
endmodule : vcmp_startup

// *** logic/vcmp_ctrl.sv ***
// Purpose: Control and status logic for one voltage comparator
// Assumes: APB slave, 10 MHz clock, analog core outside
// Notes: Core output is asynchronous and is synchronised here
//
// Functional notes
// - Result is one when positive exceeds negative
// - Result masked during start-up after enable
// - Pad drive enable puts result on pad
// - Two-bit hysteresis field, off plus three
// - Negative select: pin, DAC or reference
// - Low-current bit drives core reduced-current mode
// - Enabled block drives result as event
// - Flag sets on selected result transition
// - Interrupt enable bit gates the request
// - Request while enable and flag both set
// - Idle sleep behaves as active
// - Standby halts unless keep-running; no status update (the flag still updates in standby here while clk_kept is high)
// - Power-down disables comparison and pad drive
// - Debug halt neither stops nor resets
// - Peripheral clock only; no change protection
// - Edge codes: 0 both, 2 fall, 3 rise
// - Writing one clears flag, zero keeps
// - State bit follows result through synchroniser
// - Invert bit inverts result before all users
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`include "vcmp_regs.svh"
module vcmp_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`VCMP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// System state
	input wire vcmp_pkg::vcmp_sleep_t sleep_state,
	input wire logic clk_kept,
	// Analog core
	input wire logic core_result,
	output vcmp_pkg::vcmp_core_ctl_t core_ctl,
	// Pad, event and interrupt
	output logic pad_out,
	output logic pad_oe_n,
	output logic compare_event,
	output logic compare_irq
);
	import vcmp_pkg::*;

	localparam int CNT_W = 10;
	localparam logic [CNT_W-1:0] START_CYC = CNT_W'(`VCMP_START_CYC);
	localparam logic [CNT_W-1:0] VREF_CYC = CNT_W'(`VCMP_VREF_START_CYC);

	// ==========================================================
	// Register state
	logic [7:0] main_q, main_d;
	logic [7:0] mux_q, mux_d;
	logic [7:0] irqen_q, irqen_d;
	logic flag_q, flag_d;
	logic pad_q, pad_d;
	logic evt_q, evt_d;
	logic [31:0] rdata_q, rdata_d;

	logic wr_acc, rd_acc, addr_ok, clr_hit;
	logic enabled, running, status_upd, ready;
	logic res_sync, res_prev, res_cur, res_old, edge_hit;
	logic inv;
	vcmp_edge_t edge_sel;

	// APB decode; no wait states, unmapped addresses answer with an error
	// Reads are fetched in the setup cycle so that prdata comes from a flop yet
	// already stands at the edge that completes the access phase
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && !penable && !pwrite;
	assign addr_ok = (paddr == `VCMP_ADDR_MAIN) || (paddr == `VCMP_ADDR_MUX) ||
		(paddr == `VCMP_ADDR_IRQEN) || (paddr == `VCMP_ADDR_STAT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = rdata_q;

	// ==========================================================
	// Sleep handling
	// Power-down stops everything; standby only with keep_running_asleep
	// Idle and active differ only for the processor, so they share one branch
	always_comb begin
		enabled = main_q[`VCMP_MAIN_ENABLE];
		running = 1'b0;
		status_upd = 1'b0;
		case (sleep_state)
			VCMP_SLP_ACTIVE, VCMP_SLP_IDLE: begin
				running = enabled;
				status_upd = 1'b1;
			end
			VCMP_SLP_STANDBY: begin
				running = enabled && main_q[`VCMP_MAIN_RUNSTBY];
				status_upd = clk_kept;
			end
			VCMP_SLP_PDOWN: begin
				running = 1'b0;
				status_upd = 1'b0;
			end
			default: begin
				running = 1'b0;
				status_upd = 1'b0;
			end
		endcase
	end

	// Core control fields drive the analog core directly
	// Hysteresis and low current are passed through; the core gives them meaning
	always_comb begin
		core_ctl.enable = running;
		core_ctl.low_current_select = main_q[`VCMP_MAIN_LP];
		core_ctl.hysteresis_select = main_q[`VCMP_MAIN_HYS_LO +: 2];
		core_ctl.negative_source_select = vcmp_neg_t'(mux_q[`VCMP_MUX_NEG_LO +: 2]);
	end

	// ==========================================================
	// Result path: synchronise, then invert, then mask by start-up
	// Core is assumed to output one when positive exceeds negative
	vcmp_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(core_result),
		.sync_out(res_sync),
		.sync_prev(res_prev)
	);

	// Reference start-up is far longer, so it picks the longer load
	// A source change while enabled does not restart the timer; re-enable to wait again
	vcmp_startup #(.CNT_W(CNT_W)) u_start (
		.clk(clk),
		.rst_n(rst_n),
		.enable(running),
		.load_val((mux_q[`VCMP_MUX_NEG_LO +: 2] == VCMP_NEG_VREF) ? VREF_CYC : START_CYC),
		.ready(ready)
	);

	assign inv = mux_q[`VCMP_MUX_INVERT];
	assign res_cur = res_sync ^ inv;
	assign res_old = res_prev ^ inv;
	assign edge_sel = vcmp_edge_t'(main_q[`VCMP_MAIN_EDGE_LO +: 2]);

	// Edge qualifier; reserved code raises nothing
	// Both edge stages pass the same invert, so flipping it never fakes an edge
	always_comb begin
		case (edge_sel)
			VCMP_EDGE_BOTH: edge_hit = res_cur ^ res_old;
			VCMP_EDGE_FALL: edge_hit = !res_cur && res_old;
			VCMP_EDGE_RISE: edge_hit = res_cur && !res_old;
			default: edge_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Register writes and flag; no change protection on any register
	// Only byte lane zero carries register bits; other lanes are ignored
	assign clr_hit = wr_acc && (paddr == `VCMP_ADDR_STAT) && pstrb[0] && pwdata[`VCMP_STAT_FLAG];
	always_comb begin
		main_d = main_q;
		mux_d = mux_q;
		irqen_d = irqen_q;
		flag_d = flag_q;
		if (wr_acc && pstrb[0]) begin
			case (paddr)
				`VCMP_ADDR_MAIN: main_d = pwdata[7:0];
				`VCMP_ADDR_MUX: mux_d = pwdata[7:0] & `VCMP_MASK_MUX;
				`VCMP_ADDR_IRQEN: irqen_d = pwdata[7:0] & `VCMP_MASK_IRQEN;
				default: ;
			endcase
		end
		if (clr_hit) begin
			flag_d = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (ready && status_upd && edge_hit) begin
			flag_d = 1'b1;
		end
	end

	// Pad and event are registered; low while stopped or starting up
	always_comb begin
		evt_d = running && ready && res_cur;
		pad_d = running && ready && res_cur && main_q[`VCMP_MAIN_PAD];
	end

	// Read mux; state bit only valid while enabled
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_acc) begin
			case (paddr)
				`VCMP_ADDR_MAIN: rdata_d[7:0] = main_q;
				`VCMP_ADDR_MUX: rdata_d[7:0] = mux_q;
				`VCMP_ADDR_IRQEN: rdata_d[7:0] = irqen_q;
				`VCMP_ADDR_STAT: begin
					rdata_d[`VCMP_STAT_FLAG] = flag_q;
					rdata_d[`VCMP_STAT_STATE] = running && ready && res_cur;
				end
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// All state on the peripheral clock; debug has no input here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			main_q <= `VCMP_RST_MAIN;
			mux_q <= `VCMP_RST_MUX;
			irqen_q <= `VCMP_RST_IRQEN;
			flag_q <= 1'b0;
			pad_q <= 1'b0;
			evt_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			main_q <= main_d;
			mux_q <= mux_d;
			irqen_q <= irqen_d;
			flag_q <= flag_d;
			pad_q <= pad_d;
			evt_q <= evt_d;
			rdata_q <= rdata_d;
		end
	end

	// Read data stands from its flop through the whole access phase
	assign pad_out = pad_q;
	assign pad_oe_n = !main_q[`VCMP_MAIN_PAD] || !running;
	assign compare_event = evt_q;
	assign compare_irq = flag_q && irqen_q[0];

	// ==========================================================
	// Checks
	// Flag set, clear and hold
	flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		ready && status_upd && edge_hit |=> flag_q)
		else $error("flag did not set on qualified edge");
	flag_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
		clr_hit && !(ready && status_upd && edge_hit) |=> !flag_q)
		else $error("flag not cleared by write of one");
	flag_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		flag_q && !clr_hit |=> flag_q)
		else $error("flag dropped without clear");
	rsvd_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
		edge_sel == VCMP_EDGE_RSVD && !flag_q |=> !flag_q)
		else $error("reserved edge code raised a flag");

	// Interrupt request follows flag and enable
	irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_acc && pstrb[0] && paddr == `VCMP_ADDR_IRQEN && !pwdata[0] |=> !compare_irq)
		else $error("interrupt not gated by enable");
	irq_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		compare_irq && !clr_hit && irqen_d[0] |=> compare_irq)
		else $error("request released before flag clear");

	// Sleep states
	pdown_pad_a: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_state == VCMP_SLP_PDOWN |=> !pad_q && !compare_event)
		else $error("output active in power-down");
	pdown_oe_a: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_state == VCMP_SLP_PDOWN |-> pad_oe_n && !core_ctl.enable)
		else $error("pad or core enabled in power-down");
	stby_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_state == VCMP_SLP_STANDBY && !main_q[`VCMP_MAIN_RUNSTBY] |-> pad_oe_n)
		else $error("pad driven in halted standby");
	stby_run_a: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_state == VCMP_SLP_STANDBY && main_q[`VCMP_MAIN_RUNSTBY] && enabled |-> core_ctl.enable)
		else $error("keep-running core stopped in standby");
	stby_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_state == VCMP_SLP_STANDBY && !clk_kept && !flag_q |=> !flag_q)
		else $error("flag updated in standby without clock");

	// Start-up and result paths
	start_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(running) |=> !ready [*8])
		else $error("result valid too early after enable");
	event_path_a: assert property (@(posedge clk) disable iff (!rst_n)
		running && ready && $past(running) |=> compare_event == $past(res_cur))
		else $error("event does not follow result");
	pad_path_a: assert property (@(posedge clk) disable iff (!rst_n)
		running && ready && main_q[`VCMP_MAIN_PAD] |=> pad_q == $past(res_cur))
		else $error("pad does not follow result");

	// Register writes
	wr_land_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_acc && pstrb[0] && paddr == `VCMP_ADDR_MAIN |=> main_q == $past(pwdata[7:0]))
		else $error("control write did not land");
	mux_land_a: assert property (@(posedge clk) disable iff (!rst_n)
		wr_acc && pstrb[0] && paddr == `VCMP_ADDR_MUX |=> mux_q == ($past(pwdata[7:0]) & `VCMP_MASK_MUX))
		else $error("source select write did not land");

	// Main scenarios
	flag_set_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(flag_q));
	irq_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(compare_irq));
	stby_run_c: cover property (@(posedge clk) disable iff (!rst_n)
		sleep_state == VCMP_SLP_STANDBY && running);
	pad_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(pad_q));
	vref_start_c: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(running) && mux_q[`VCMP_MUX_NEG_LO +: 2] == VCMP_NEG_VREF);
endmodule : vcmp_ctrl

// *** bench/vcmp_core_model.sv ***
// Purpose: Behavioural analog comparator core behind the control block
// Assumes: Levels in millivolts, driven by the bench
// Notes: A disabled core toggles its output so stale levels never pass
`timescale 1ns/100ps
module vcmp_core_model (
	// Control from the block
	input wire vcmp_pkg::vcmp_core_ctl_t core_ctl,
	// Analog levels
	input wire logic [11:0] pos_mv,
	input wire logic [11:0] pin_mv,
	input wire logic [11:0] vref_mv,
	input wire logic [11:0] dac_mv,
	// Comparator output
	output logic core_result
);
	import vcmp_pkg::*;
	logic [11:0] neg_mv;
	logic raw;
	int age;
	// =====================================
	// Negative source choice
	always_comb begin
		case (core_ctl.negative_source_select)
			VCMP_NEG_VREF: neg_mv = vref_mv;
			VCMP_NEG_DAC: neg_mv = dac_mv;
			default: neg_mv = pin_mv;
		endcase
	end
	// While enabled, output is one only when positive is above negative; unknown enable counts as off
	assign raw = (core_ctl.enable === 1'b1) ? (pos_mv > neg_mv) : !core_result;
	// Output takes raw once it has differed for the whole delay, so a short glitch
	// or a change of speed never lets an old level land late; polled off the clock edges
	// Reduced current trades speed: answer ten times slower
	initial begin
		core_result = 1'b0;
		age = 0;
		#5;
		forever begin
			if (raw === core_result) begin
				age = 0;
			end else begin
				age = age + 10;
				if (age >= ((core_ctl.low_current_select === 1'b1) ? 400 : 40)) begin
					core_result = raw;
					age = 0;
				end
			end
			#10;
		end
	end
endmodule : vcmp_core_model

// *** bench/analog_comparator_control_test.sv ***
// Purpose: Self-checking bench for the comparator control block
// Assumes: APB read data stands at the edge that completes the access phase
// Notes: Reads queue their expected value; a monitor compares them
`timescale 1ns/100ps
`include "vcmp_regs.svh"
module analog_comparator_control_test;
	import vcmp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [5:0] paddr = 6'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h1;
	logic [31:0] prdata;
	logic pready, pslverr, core_result, pad_out, pad_oe_n, compare_event, compare_irq;
	vcmp_sleep_t sleep_state = VCMP_SLP_ACTIVE;
	logic clk_kept = 1'b0;
	vcmp_core_ctl_t core_ctl;
	logic [11:0] pos_mv = 12'h200;
	logic [11:0] pin_mv = 12'h100;
	logic [11:0] vref_mv = 12'h300;
	logic [11:0] dac_mv = 12'h300;
	logic [31:0] rd_q[$];
	logic f1, f2;
	logic [7:0] v;
	int errors = 0;
	int checked = 0;
	always #50 clk = ~clk;
	vcmp_ctrl uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sleep_state(sleep_state), .clk_kept(clk_kept),
		.core_result(core_result), .core_ctl(core_ctl), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.compare_event(compare_event), .compare_irq(compare_irq));
	vcmp_core_model core (.core_ctl(core_ctl), .pos_mv(pos_mv), .pin_mv(pin_mv),
		.vref_mv(vref_mv), .dac_mv(dac_mv), .core_result(core_result));
	// =====================================
	// Comparison and closing
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	// Read data is taken at the edge that completes the access phase
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			check("prdata", prdata, rd_q.pop_front());
		end
	end
	// =====================================
	// APB master: holds the request until pready is seen high
	task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) begin
			rd_q.push_back(e);
		end
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (!pready) begin
			@(posedge clk);
		end
		check("pslverr", pslverr, err);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, e, 1'b0);
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic volt(input logic [11:0] p);
		@(posedge clk);
		pos_mv <= p;
		cyc(12);
	endtask : volt
	task automatic slp(input vcmp_sleep_t s);
		@(posedge clk);
		sleep_state <= s;
		cyc(3);
	endtask : slp
	// Clear the flag, make one result change, read state and flag
	task automatic edge_step(input logic [11:0] p, input logic st, input logic f);
		wr(`VCMP_ADDR_STAT, 32'h1);
		volt(p);
		rd(`VCMP_ADDR_STAT, {27'h0, st, 3'h0, f});
	endtask : edge_step
	// Hang guard
	initial begin
		cyc(20000);
		errors++;
		test_done();
	end
	// =====================================
	// Main sequence
	initial begin
		void'($urandom(49));
		cyc(6);
		rst_n <= 1'b1;
		rd(`VCMP_ADDR_MAIN, 32'h0);
		rd(`VCMP_ADDR_MUX, 32'h0);
		rd(`VCMP_ADDR_IRQEN, 32'h0);
		rd(`VCMP_ADDR_STAT, 32'h0);
		apb(1'b0, 6'h04, 32'h0, 32'h0, 1'b1);
		check("pad_oe_n", pad_oe_n, 1'b1);
		$display("test reset done");
		wr(`VCMP_ADDR_MUX, 32'hffff_ffff);
		rd(`VCMP_ADDR_MUX, 32'h83);
		wr(`VCMP_ADDR_IRQEN, 32'hff);
		rd(`VCMP_ADDR_IRQEN, 32'h1);
		wr(`VCMP_ADDR_IRQEN, 32'h0);
		wr(`VCMP_ADDR_MUX, 32'h0);
		wr(`VCMP_ADDR_STAT, 32'hff);
		rd(`VCMP_ADDR_STAT, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = {4'h0, 1'($urandom % 2), i[1:0], 1'b0};
			wr(`VCMP_ADDR_MAIN, {24'h0, v});
			cyc(1);
			check("hys", core_ctl.hysteresis_select, v[2:1]);
			check("lowcur", core_ctl.low_current_select, v[3]);
			rd(`VCMP_ADDR_MAIN, {24'h0, v});
		end
		$display("test registers done");
		wr(`VCMP_ADDR_MAIN, 32'h41);
		cyc(10);
		check("event", compare_event, 1'b0);
		cyc(25);
		check("event", compare_event, 1'b1);
		check("pad", pad_out, 1'b1);
		check("pad_oe_n", pad_oe_n, 1'b0);
		rd(`VCMP_ADDR_STAT, 32'h10);
		volt(12'h080);
		check("event", compare_event, 1'b0);
		$display("test startup done");
		for (int inv = 0; inv < 2; inv++) begin
			for (int m = 0; m < 4; m++) begin
				wr(`VCMP_ADDR_MUX, {24'h0, inv[0], 7'h0});
				wr(`VCMP_ADDR_MAIN, {24'h0, 2'b01, m[1:0], 4'h1});
				volt(12'h080);
				f1 = (m == 0) || (m == 3 && inv == 0) || (m == 2 && inv == 1);
				f2 = (m == 0) || (m == 3 && inv == 1) || (m == 2 && inv == 0);
				edge_step(12'h200, !inv[0], f1);
				edge_step(12'h080, inv[0], f2);
			end
		end
		$display("test edges done");
		wr(`VCMP_ADDR_MUX, 32'h0);
		wr(`VCMP_ADDR_MAIN, 32'h41);
		wr(`VCMP_ADDR_STAT, 32'h1);
		wr(`VCMP_ADDR_IRQEN, 32'h1);
		cyc(2);
		check("irq", compare_irq, 1'b0);
		volt(12'h200);
		check("irq", compare_irq, 1'b1);
		wr(`VCMP_ADDR_IRQEN, 32'h0);
		cyc(2);
		check("irq", compare_irq, 1'b0);
		wr(`VCMP_ADDR_IRQEN, 32'h1);
		wr(`VCMP_ADDR_STAT, 32'h0);
		cyc(2);
		check("irq", compare_irq, 1'b1);
		wr(`VCMP_ADDR_STAT, 32'h1);
		cyc(2);
		check("irq", compare_irq, 1'b0);
		$display("test irq done");
		for (int s = 0; s < 4; s++) begin
			if (s != 1) begin
				wr(`VCMP_ADDR_MUX, s);
				@(posedge clk);
				pin_mv <= (s == 0) ? 12'h100 : 12'h300;
				vref_mv <= (s == 2) ? 12'h100 : 12'h300;
				dac_mv <= (s == 3) ? 12'h100 : 12'h300;
				cyc(12);
				check("negsel", core_ctl.negative_source_select, s[1:0]);
				check("event", compare_event, 1'b1);
			end
		end
		vref_mv <= 12'h100;
		wr(`VCMP_ADDR_MAIN, 32'h0);
		wr(`VCMP_ADDR_MUX, 32'h2);
		wr(`VCMP_ADDR_MAIN, 32'h41);
		cyc(300);
		check("event", compare_event, 1'b0);
		cyc(320);
		check("event", compare_event, 1'b1);
		$display("test sources done");
		wr(`VCMP_ADDR_MUX, 32'h3);
		wr(`VCMP_ADDR_STAT, 32'h1);
		slp(VCMP_SLP_IDLE);
		volt(12'h080);
		check("irq", compare_irq, 1'b1);
		check("event", compare_event, 1'b0);
		wr(`VCMP_ADDR_STAT, 32'h1);
		slp(VCMP_SLP_STANDBY);
		check("enable", core_ctl.enable, 1'b0);
		check("pad_oe_n", pad_oe_n, 1'b1);
		wr(`VCMP_ADDR_MAIN, 32'hc1);
		cyc(30);
		volt(12'h200);
		check("event", compare_event, 1'b1);
		check("pad", pad_out, 1'b1);
		check("irq", compare_irq, 1'b0);
		@(posedge clk);
		clk_kept <= 1'b1;
		volt(12'h080);
		check("irq", compare_irq, 1'b1);
		wr(`VCMP_ADDR_STAT, 32'h1);
		slp(VCMP_SLP_PDOWN);
		check("pad_oe_n", pad_oe_n, 1'b1);
		check("enable", core_ctl.enable, 1'b0);
		slp(VCMP_SLP_ACTIVE);
		cyc(30);
		check("pad_oe_n", pad_oe_n, 1'b0);
		$display("test sleep done");
		test_done();
	end
endmodule : analog_comparator_control_test
